/* logic/btm_pkg.sv */
package btm_pkg;

   // Grant low time and request hold time, in clocks
   localparam int unsigned GNT_MIN_LOW_CLKS = 2;
   localparam int unsigned REQ_MIN_HOLD_CLKS = 2;
   localparam int unsigned GNT_CNT_W = 2;
   localparam int unsigned ADDR_W = 32;

   // Reset values
   localparam logic RST_GNT_N = 1'b1;
   localparam logic RST_DRIVE = 1'b1;

   // Transaction attributes kept for reissue
   typedef struct packed {
      logic [31:0] addr;
      logic [3:0]  size;
      logic        write;
      logic [3:0]  byte_en_n;
   } btm_xact_type;

   // Sampled bus responses, active low as on the pins
   typedef struct packed {
      logic ack_n;
      logic redo_n;
      logic fault_n;
   } btm_resp_type;

   // Bus sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_FIRST = 5'h02,
      ST_REST  = 5'h04,
      ST_GRANT = 5'h08,
      ST_HAND  = 5'h10
   } btm_state_type;

endpackage

/* logic/btm_sync.sv */
`timescale 1ns/1ns
// Two-stage synchroniser for a group of asynchronous pins
module btm_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   input  wire logic             i_core_clk, // Core clock
   input  wire logic             i_reset,    // Async reset, high
   input  wire logic [WIDTH-1:0] i_async,    // Pin levels
   output logic      [WIDTH-1:0] o_sync      // Synchronised levels
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } btm_sync_state_type;

   btm_sync_state_type state;
   btm_sync_state_type next_state;

   // Only the second stage is visible outside
   always_comb begin
      next_state.meta = i_async;
      next_state.stable = state.meta;
   end

   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         state <= {RST_VAL, RST_VAL};
      end else begin
         state <= next_state;
      end
   end

   assign o_sync = state.stable;

endmodule // btm_sync

/* logic/btm_arbiter.sv */
`timescale 1ns/1ns
module btm_arbiter (
   input  wire logic                 i_core_clk,                     // Core clock
   input  wire logic                 i_reset,                        // Async reset, high
   input  wire logic                 i_xact_req,                     // Internal request
   input  wire btm_pkg::btm_xact_type i_xact,                        // Request attributes
   input  wire logic                 i_last,                         // Last data of transfer
   input  wire logic                 i_ack_n,                        // Transfer acknowledge
   input  wire logic                 i_redo_n,                       // Redo request
   input  wire logic                 i_transfer_fault_n,             // Transfer fault
   input  wire logic                 i_external_mastership_request_n, // Async DMA request
   output logic                      o_xact_taken,                   // Request accepted
   output logic                      o_start,                        // Address phase pulse
   output btm_pkg::btm_xact_type     o_bus_xact,                     // Presented transaction
   output logic                      o_cycle_active,                 // Transfer in progress
   output logic                      o_done,                         // Transfer completed
   output logic                      o_bus_error,                    // Bus error exception
   output logic [31:0]               o_fault_addr,                   // Faulting address
   output logic                      o_mastership_released_n,        // Grant, active low
   output logic                      o_drive_en                      // Bus driver enable
);

   typedef struct packed {
      btm_pkg::btm_state_type       fsm;
      btm_pkg::btm_xact_type        xact;
      logic                         pending;
      logic [btm_pkg::GNT_CNT_W-1:0] gnt_cnt;
      logic                         taken;
      logic                         start;
      logic                         active;
      logic                         done;
      logic                         bus_error;
      logic [31:0]                  fault_addr;
      logic                         gnt_n;
      logic                         drive;
   } btm_arb_state_type;

   btm_arb_state_type state;
   btm_arb_state_type next_state;
   btm_pkg::btm_resp_type resp;
   logic [3:0] synced;
   logic req;

   btm_sync #(
      .WIDTH   (4),
      .RST_VAL (4'hf)
   ) u_sync (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_async    ({i_external_mastership_request_n, i_ack_n, i_redo_n,
                    i_transfer_fault_n}),
      .o_sync     (synced)
   );

   // Active-high mastership request from the synchronised pin
   assign req = ~synced[3];
   assign resp = '{ack_n: synced[2], redo_n: synced[1], fault_n: synced[0]};

   // Sequencer: one transfer at a time, grant only between transfers or on a redo in the first phase
   always_comb begin
      next_state = state;
      next_state.taken = 1'b0;
      next_state.start = 1'b0;
      next_state.done = 1'b0;
      next_state.bus_error = 1'b0;
      // Remember internal need while the bus is lent out
      if (i_xact_req && !state.pending) begin
         next_state.pending = 1'b1;
         next_state.xact = i_xact;
         next_state.taken = 1'b1;
      end
      case (state.fsm)
         btm_pkg::ST_IDLE: begin
            if (req) begin
               next_state.fsm = btm_pkg::ST_GRANT;
               next_state.gnt_n = 1'b0;
               next_state.drive = 1'b0;
               next_state.gnt_cnt = '0;
            end else if (state.pending) begin
               next_state.fsm = btm_pkg::ST_FIRST;
               next_state.start = 1'b1;
               next_state.active = 1'b1;
            end
         end
         btm_pkg::ST_FIRST: begin
            if (!resp.fault_n) begin
               next_state.bus_error = 1'b1;
               next_state.fault_addr = state.xact.addr;
               next_state.fsm = btm_pkg::ST_IDLE;
               next_state.active = 1'b0;
               next_state.pending = 1'b0;
            end else if (!resp.ack_n) begin
               if (i_last) begin
                  next_state.fsm = btm_pkg::ST_IDLE;
                  next_state.active = 1'b0;
                  next_state.done = 1'b1;
                  next_state.pending = 1'b0;
               end else begin
                  next_state.fsm = btm_pkg::ST_REST;
               end
            end else if (!resp.redo_n) begin
               next_state.active = 1'b0;
               if (req) begin
                  next_state.fsm = btm_pkg::ST_GRANT;
                  next_state.gnt_n = 1'b0;
                  next_state.drive = 1'b0;
                  next_state.gnt_cnt = '0;
               end else begin
                  next_state.fsm = btm_pkg::ST_FIRST;
                  next_state.start = 1'b1;
                  next_state.active = 1'b1;
               end
            end
         end
         btm_pkg::ST_REST: begin
            if (!resp.ack_n && i_last) begin
               next_state.fsm = btm_pkg::ST_IDLE;
               next_state.active = 1'b0;
               next_state.done = 1'b1;
               next_state.pending = 1'b0;
            end
         end
         btm_pkg::ST_GRANT: begin
            if (state.gnt_cnt != btm_pkg::GNT_CNT_W'(btm_pkg::GNT_MIN_LOW_CLKS)) begin
               next_state.gnt_cnt = state.gnt_cnt + 1'b1;
            end
            if (!req) begin
               next_state.gnt_n = 1'b1;
               next_state.drive = 1'b1;
               next_state.fsm = btm_pkg::ST_HAND;
            end else if (state.gnt_cnt >= btm_pkg::GNT_CNT_W'(btm_pkg::GNT_MIN_LOW_CLKS - 1)
                         && state.pending) begin
               next_state.gnt_n = 1'b1;
            end
         end
         btm_pkg::ST_HAND: begin
            if (req) begin
               next_state.fsm = btm_pkg::ST_GRANT;
               next_state.gnt_n = 1'b0;
               next_state.drive = 1'b0;
               next_state.gnt_cnt = '0;
            end else if (state.pending) begin
               next_state.fsm = btm_pkg::ST_FIRST;
               next_state.start = 1'b1;
               next_state.active = 1'b1;
            end else begin
               next_state.fsm = btm_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state.fsm = btm_pkg::ST_IDLE;
         end
      endcase
   end

   // Fault address has no defined reset meaning; cleared for determinism
   always_ff @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         state.fsm <= btm_pkg::ST_IDLE;
         state.xact <= '0;
         state.pending <= 1'b0;
         state.gnt_cnt <= '0;
         state.taken <= 1'b0;
         state.start <= 1'b0;
         state.active <= 1'b0;
         state.done <= 1'b0;
         state.bus_error <= 1'b0;
         state.fault_addr <= '0;
         state.gnt_n <= btm_pkg::RST_GNT_N;
         state.drive <= btm_pkg::RST_DRIVE;
      end else begin
         state <= next_state;
      end
   end

   assign o_xact_taken = state.taken;
   assign o_start = state.start;
   assign o_bus_xact = state.xact;
   assign o_cycle_active = state.active;
   assign o_done = state.done;
   assign o_bus_error = state.bus_error;
   assign o_fault_addr = state.fault_addr;
   assign o_mastership_released_n = state.gnt_n;
   assign o_drive_en = state.drive;

   // Two sampled clocks of grant low
   sequence s_gnt_low_two;
      !state.gnt_n [*2];
   endsequence

   // Grant low is held at least two clocks
   property p_gnt_min_low;
      @(posedge i_core_clk) disable iff (i_reset)
         $fell(state.gnt_n) |-> s_gnt_low_two;
   endproperty
   a_gnt_min_low: assert property (p_gnt_min_low) else $error("grant low too short");

   // Drivers off whenever grant is low
   property p_float_on_grant;
      @(posedge i_core_clk) disable iff (i_reset)
         !state.gnt_n |-> !state.drive;
   endproperty
   a_float_on_grant: assert property (p_float_on_grant) else $error("driving while granted");

   // Withdrawal ends grant next edge with drivers on
   property p_release;
      @(posedge i_core_clk) disable iff (i_reset)
         (state.fsm == btm_pkg::ST_GRANT && !req) |=> (state.gnt_n && state.drive);
   endproperty
   a_release: assert property (p_release) else $error("grant not released");

   // No transfer while bus lent
   property p_no_reclaim;
      @(posedge i_core_clk) disable iff (i_reset)
         (state.fsm == btm_pkg::ST_GRANT && req) |=> (!state.start && !state.drive);
   endproperty
   a_no_reclaim: assert property (p_no_reclaim) else $error("bus reclaimed early");

   // Fault in first phase raises bus error
   property p_fault;
      @(posedge i_core_clk) disable iff (i_reset)
         (state.fsm == btm_pkg::ST_FIRST && !resp.fault_n) |=> (state.bus_error && !state.done);
   endproperty
   a_fault: assert property (p_fault) else $error("fault not taken");

   // Redo alone with no request reissues
   property p_reissue;
      @(posedge i_core_clk) disable iff (i_reset)
         (state.fsm == btm_pkg::ST_FIRST && resp.fault_n && resp.ack_n && !resp.redo_n && !req)
         |=> (state.start && $stable(state.xact.addr));
   endproperty
   a_reissue: assert property (p_reissue) else $error("no reissue");

   // Redo with request grants bus
   property p_redo_grant;
      @(posedge i_core_clk) disable iff (i_reset)
         (state.fsm == btm_pkg::ST_FIRST && resp.fault_n && resp.ack_n && !resp.redo_n && req)
         |=> !state.gnt_n;
   endproperty
   a_redo_grant: assert property (p_redo_grant) else $error("no grant after redo");

   // Late redo and fault ignored
   property p_late_ignore;
      @(posedge i_core_clk) disable iff (i_reset)
         (state.fsm == btm_pkg::ST_REST && resp.ack_n) |=> (state.active && !state.bus_error);
   endproperty
   a_late_ignore: assert property (p_late_ignore) else $error("late response acted on");

   // Ack in the first phase completes, whatever redo does
   property p_ack_wins;
      @(posedge i_core_clk) disable iff (i_reset)
         (state.fsm == btm_pkg::ST_FIRST && resp.fault_n && !resp.ack_n && i_last)
         |=> (state.done && !state.start && !state.bus_error);
   endproperty
   a_ack_wins: assert property (p_ack_wins) else $error("redo not ignored under ack");

   // Request on an idle bus: grant, drivers off, no transfer
   property p_idle_grant;
      @(posedge i_core_clk) disable iff (i_reset)
         (state.fsm == btm_pkg::ST_IDLE && req)
         |=> (!state.gnt_n && !state.drive && !state.start);
   endproperty
   a_idle_grant: assert property (p_idle_grant) else $error("idle bus not lent");

   // Lent bus with internal need for two clocks
   sequence s_lent_with_need;
      (!state.gnt_n && state.pending) [*2];
   endsequence

   // Internal need raises grant on the next edge
   property p_need_release;
      @(posedge i_core_clk) disable iff (i_reset)
         s_lent_with_need |=> state.gnt_n;
   endproperty
   a_need_release: assert property (p_need_release) else $error("grant kept despite need");

endmodule // btm_arbiter

/* bench/btm_partner.sv */
`timescale 1ns/1ns
// Far side: memory responder and DMA master, both behavioural
module btm_partner (
   input  wire logic       i_core_clk,  // Core clock
   input  wire logic       i_reset,     // Async reset, high
   input  wire logic [2:0] i_mode,      // Answer script taken at start
   input  wire logic       i_dma_want,  // Bench wants the bus lent
   input  wire logic       i_start,     // Address phase from device
   input  wire logic       i_end,       // Done or bus error seen
   input  wire logic       i_gnt_n,     // Grant from device
   output logic            o_ack_n,     // Acknowledge pin
   output logic            o_redo_n,    // Redo pin
   output logic            o_fault_n,   // Transfer fault pin
   output logic            o_last,      // Last beat, pin timed
   output logic            o_req_n,     // Mastership request pin
   output logic            o_dma_drive  // Far master drives bus
);
   logic       busy;
   logic [2:0] cur;
   logic [1:0] step;
   logic       hold;
   logic       owned;

   // Answer held until the device reacts; a grant to the far master also ends it
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         busy <= 1'h0;
         cur  <= 3'h0;
         step <= 2'h0;
      end else if (i_start) begin
         busy <= 1'h1;
         cur  <= i_mode;
         step <= 2'h0;
      end else if (busy && (i_end || !i_gnt_n)) begin
         busy <= 1'h0;
      end else if (busy && step != 2'h3) begin
         step <= step + 2'h1;
      end
   end

   // answers; lines pulled high when released
   always_comb begin
      {o_ack_n, o_redo_n, o_fault_n, o_last} = 4'hf;
      if (busy) begin
         case (cur)
            3'h0: o_ack_n = 1'h0;
            3'h1: o_redo_n = (step != 2'h0); // One beat, else seen twice
            3'h2: o_fault_n = 1'h0;
            3'h3: {o_ack_n, o_redo_n} = 2'h0;
            3'h4: {o_ack_n, o_fault_n} = 2'h0;
            default: begin // Beat, late redo and fault, last beat
               o_ack_n   = (step == 2'h1);
               o_redo_n  = (step != 2'h1);
               o_fault_n = (step != 2'h1);
               o_last    = (step >= 2'h2);
            end
         endcase
      end
   end

   // request level held two cycles at least
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         o_req_n <= 1'h1;
         hold    <= 1'h0;
      end else if (hold) begin
         hold <= 1'h0;
      end else if (o_req_n == i_dma_want) begin
         o_req_n <= !i_dma_want;
         hold    <= 1'h1;
      end
   end

   // far master drives from grant until it withdraws
   always @(posedge i_core_clk or posedge i_reset) begin
      if (i_reset) begin
         owned <= 1'h0;
      end else begin
         owned <= !o_req_n && (owned || !i_gnt_n);
      end
   end
   assign o_dma_drive = owned;
endmodule // btm_partner

/* bench/btm_arbiter_tb.sv */
`timescale 1ns/1ns
module btm_arbiter_tb;
   logic i_core_clk, i_reset, i_xact_req, dma_want;
   logic p_ack_n, p_redo_n, p_fault_n, p_last, p_req_n, dma_drive;
   logic o_xact_taken, o_start, o_cycle_active, o_done, o_bus_error;
   logic o_mastership_released_n, o_drive_en;
   logic [31:0] o_fault_addr, seed;
   logic [2:0] mode;
   logic [1:0] last_q;
   btm_pkg::btm_xact_type i_xact, o_bus_xact, cur_xact;
   int bad_count, n_checks, n_start, n_end, n_done, n_err, n_gnt, n_up, glow;

   btm_arbiter i_dut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_xact_req(i_xact_req),
      .i_xact(i_xact), .i_last(last_q[1]), .i_ack_n(p_ack_n), .i_redo_n(p_redo_n),
      .i_transfer_fault_n(p_fault_n), .i_external_mastership_request_n(p_req_n),
      .o_xact_taken(o_xact_taken), .o_start(o_start), .o_bus_xact(o_bus_xact),
      .o_cycle_active(o_cycle_active), .o_done(o_done), .o_bus_error(o_bus_error),
      .o_fault_addr(o_fault_addr), .o_mastership_released_n(o_mastership_released_n),
      .o_drive_en(o_drive_en));
   btm_partner i_far (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_mode(mode),
      .i_dma_want(dma_want), .i_start(o_start), .i_end(o_done | o_bus_error),
      .i_gnt_n(o_mastership_released_n), .o_ack_n(p_ack_n), .o_redo_n(p_redo_n),
      .o_fault_n(p_fault_n), .o_last(p_last), .o_req_n(p_req_n), .o_dma_drive(dma_drive));

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // Legal sizes only, so refusals never mask the answer
   function automatic btm_pkg::btm_xact_type mk(input logic [31:0] r);
      btm_pkg::btm_xact_type x;
      x.addr = r;
      x.size = 4'(r[10:8] % 3'h5);
      x.write = r[11];
      x.byte_en_n = r[15:12];
      return x;
   endfunction

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Bounded wait for a counter to move past its base
   task automatic wait_cnt(ref int cnt, input int base);
      int k;
      k = 0;
      while (cnt == base && k < 60) begin
         @(negedge i_core_clk);
         k++;
      end
      check(cnt != base, 1);
   endtask

   task automatic run_xact(input logic [2:0] m, input bit lend);
      int s0, d0, e0, g0;
      logic err;
      s0 = n_start;
      d0 = n_done;
      e0 = n_end;
      g0 = n_gnt;
      seed = lfsr(seed);
      cur_xact = mk(seed);
      i_xact = cur_xact;
      mode = m;
      i_xact_req = 1'h1;
      if (lend) begin
         // Request seen in the first data phase, with the redo
         @(negedge i_core_clk);
         dma_want = 1'h1;
         wait_cnt(n_gnt, g0);
         repeat (6) @(negedge i_core_clk);
         check(n_start - s0, 1);
         check(n_done - d0, 0);
         dma_want = 1'h0;
      end
      wait_cnt(n_end, e0);
      repeat (4) @(negedge i_core_clk);
      err = (m == 3'h2 || m == 3'h4);
      check(n_end - e0, 1);
      check(n_done - d0, !err);
      check(n_start - s0, (m == 3'h1) ? 2 : 1);
      if (err) check(o_fault_addr, cur_xact.addr);
      $display("test mode %0d lend %0d done", m, lend);
   endtask

   initial begin
      i_core_clk = 1'h0;
      forever #10 i_core_clk = ~i_core_clk;
   end

   // Events counted at the edge; pulses, mode and request retire here
   always @(posedge i_core_clk) begin
      last_q <= {last_q[0], p_last};
      if (o_xact_taken) i_xact_req <= 1'h0;
      if (o_start) mode <= 3'h0;
      if (!i_reset) begin
         if (o_start) begin
            n_start++;
            check(o_bus_xact, cur_xact);
         end
         if (o_done) n_done++;
         if (o_bus_error) n_err++;
         if (o_done || o_bus_error) n_end++;
         if (o_drive_en && dma_drive) check(1, 0);
         if (!o_mastership_released_n && o_cycle_active) check(1, 0);
         if (!o_mastership_released_n) check(o_drive_en, 1'h0);
         if (o_mastership_released_n === 1'h0) begin
            if (glow == 0) n_gnt++;
            glow++;
         end else if (glow != 0) begin
            n_up++;
            check(glow >= 2, 1);
            glow = 0;
         end
      end
   end

   initial begin
      #400000;
      bad_count++;
      test_done();
   end

   initial begin
      int s0, u0, e0;
      {i_xact_req, dma_want, mode, last_q, i_xact} = '0;
      last_q = 2'h3;
      seed = 32'hf9aba560;
      i_reset = 1'h1;
      repeat (20) @(negedge i_core_clk);
      check({o_mastership_released_n, o_drive_en, o_fault_addr}, {2'h3, 32'h0});
      i_reset = 1'h0;
      @(negedge i_core_clk);
      for (int m = 0; m < 6; m++) run_xact(3'(m), 1'b0);
      for (int i = 0; i < 12; i++) run_xact(3'(seed[18:16] % 3'h6), 1'b0);
      run_xact(3'h1, 1'b1);
      // Lend an idle bus, then ask for it back from inside
      dma_want = 1'h1;
      wait_cnt(n_gnt, n_gnt);
      check(o_drive_en, 1'h0);
      s0 = n_start;
      u0 = n_up;
      e0 = n_end;
      seed = lfsr(seed);
      cur_xact = mk(seed);
      i_xact = cur_xact;
      i_xact_req = 1'h1;
      wait_cnt(n_up, u0);
      check(n_up - u0, 1);
      repeat (6) @(negedge i_core_clk);
      check({n_start - s0, o_drive_en}, 0);
      dma_want = 1'h0;
      wait_cnt(n_start, s0);
      check(o_drive_en, 1'h1);
      wait_cnt(n_end, e0);
      check(n_done - e0 + n_err, 1);
      $display("test idle lend done");
      test_done();
   end
endmodule // btm_arbiter_tb
